// ### plcr_aspm_decode.sv
`timescale 1ns/100ps
`default_nettype none
module plcr_aspm_decode
	import plcr_pkg::*;
(
	input wire logic [1:0] field,
	output var plcr_aspm_type allow
);
	always_comb
	begin
		allow.l0s_entry_allow = (field == PLCR_ASPM_L0S) || (field == PLCR_ASPM_BOTH); // RULE_13
		allow.l1_entry_allow = (field == PLCR_ASPM_L1) || (field == PLCR_ASPM_BOTH); // RULE_13
	end
endmodule
`default_nettype wire

// ### plcr_link_control.sv
// Summary of operation
// [RULE_01] Bits 15 to 12 read zero; writes to them are ignored.
// [RULE_02] Bit 11, autonomous bandwidth interrupt enable, is read-only zero.
// [RULE_03] Bit 10, bandwidth management interrupt enable, is read-only zero.
// [RULE_04] Bit 9, autonomous width disable, is read-only zero.
// [RULE_05] Clock PM enable zero holds the clock request output low.
// [RULE_06] Clock PM enable one lets clock request free the reference clock.
// [RULE_07] Clock PM enable resets from general control bit 23.
// [RULE_08] Extended sync one lengthens the L1 exit training; resets to zero.
// [RULE_09] Common clock bit stored, resets zero, selects reported exit latencies.
// [RULE_10] Retrain and link-off bits 5 and 4 are read-only zero.
// [RULE_11] Completion boundary bit is stored only; resets to 64 bytes.
// [RULE_12] Bit 2 is reserved and reads zero.
// [RULE_13] Active state PM field gates L0s and L1 entry.
// [RULE_14] Active state PM field resets from general control bits 29:28.
// [RULE_15] Writes change only bits 8, 7, 6, 3, 1 and 0.
`timescale 1ns/100ps
`default_nettype none
module plcr_link_control
	import plcr_pkg::*;
#(
	parameter logic [15:0] L0S_LAT_COMMON = 16'h0001,
	parameter logic [15:0] L0S_LAT_SEPARATE = 16'h0002,
	parameter logic [15:0] L1_LAT_COMMON = 16'h0003,
	parameter logic [15:0] L1_LAT_SEPARATE = 16'h0004
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic clk_en,
	// Defaults from the general control register, read in the first enabled cycle after reset
	input wire logic clock_pm_default_select,
	input wire logic [1:0] active_pm_default_select,
	// Configuration access
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_addr,
	input wire logic [1:0] cfg_byte_en,
	input wire logic [15:0] cfg_wdata,
	output logic [15:0] cfg_rdata,
	// Link side
	input wire logic link_idle_clock_ok,
	output logic clkreq_out,
	output logic clkreq_oe,
	output logic extended_sync,
	output logic common_clock_config,
	output logic completion_boundary,
	output logic l0s_entry_allow,
	output logic l1_entry_allow,
	output logic [15:0] l0s_exit_latency,
	output logic [15:0] l1_exit_latency
);
	// ----------------------------------------
	// Register state
	// ----------------------------------------
	plcr_ctrl_type ctrl_q, ctrl_d;
	logic loaded_q, loaded_d;
	logic [15:0] rdata_q, rdata_d;
	logic [15:0] image;
	logic [15:0] wmask;
	logic [15:0] newval;
	logic hit;

	// Register image: all fixed bits are constant zero
	always_comb
	begin
		image = 16'h0000; // RULE_01 RULE_02 RULE_03 RULE_04 RULE_10 RULE_12
		image[PLCR_CLOCK_PM_BIT] = ctrl_q.clock_pm_enable;
		image[PLCR_EXT_SYNC_BIT] = ctrl_q.extended_sync;
		image[PLCR_COMMON_CLK_BIT] = ctrl_q.common_clock_config;
		image[PLCR_COMPL_BND_BIT] = ctrl_q.completion_boundary;
		image[PLCR_ASPM_LSB +: 2] = ctrl_q.active_state_pm_control;
	end

	assign hit = (cfg_addr == PLCR_LINK_CTRL_OFFSET);

	always_comb
	begin
		ctrl_d = ctrl_q;
		loaded_d = 1'b1;
		rdata_d = rdata_q;
		wmask = PLCR_WRITE_MASK & {{8{cfg_byte_en[1]}}, {8{cfg_byte_en[0]}}}; // RULE_15
		newval = (image & ~wmask) | (cfg_wdata & wmask); // RULE_15
		// Straps are sampled in the first enabled cycle after reset, not in reset
		if (!loaded_q)
		begin
			ctrl_d.clock_pm_enable = clock_pm_default_select; // RULE_07
			ctrl_d.active_state_pm_control = active_pm_default_select; // RULE_14
		end
		else if (cfg_wr && hit)
		begin
			ctrl_d.clock_pm_enable = newval[PLCR_CLOCK_PM_BIT];
			ctrl_d.extended_sync = newval[PLCR_EXT_SYNC_BIT]; // RULE_08
			ctrl_d.common_clock_config = newval[PLCR_COMMON_CLK_BIT]; // RULE_09
			ctrl_d.completion_boundary = newval[PLCR_COMPL_BND_BIT]; // RULE_11
			ctrl_d.active_state_pm_control = newval[PLCR_ASPM_LSB +: 2];
		end
		// Unmapped reads return zero
		if (cfg_rd)
		begin
			if (hit)
				rdata_d = image;
			else
				rdata_d = 16'h0000;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_q <= '{1'b0, PLCR_EXT_SYNC_RESET, PLCR_COMMON_CLK_RESET,
				PLCR_COMPL_BND_RESET, PLCR_ASPM_OFF};
			loaded_q <= 1'b0;
			rdata_q <= 16'h0000;
		end
		else if (clk_en)
		begin
			ctrl_q <= ctrl_d;
			loaded_q <= loaded_d;
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------
	// Link-facing outputs
	// ----------------------------------------
	plcr_aspm_type allow;
	logic clkreq_d;
	logic clkreq_q;
	logic es_q, ccc_q, rcb_q, l0s_q, l1_q;
	logic oe_q;
	logic [15:0] l0s_lat_q, l1_lat_q, l0s_lat_d, l1_lat_d;

	plcr_aspm_decode u_aspm (
		.field(ctrl_q.active_state_pm_control),
		.allow(allow)
	);

	always_comb
	begin
		// Low requests the clock; release only when enabled and the link allows it
		clkreq_d = ctrl_q.clock_pm_enable & link_idle_clock_ok; // RULE_05 RULE_06
		l0s_lat_d = ctrl_q.common_clock_config ? L0S_LAT_COMMON : L0S_LAT_SEPARATE; // RULE_09
		l1_lat_d = ctrl_q.common_clock_config ? L1_LAT_COMMON : L1_LAT_SEPARATE; // RULE_09
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			clkreq_q <= 1'b0;
			es_q <= 1'b0;
			ccc_q <= 1'b0;
			rcb_q <= 1'b0;
			l0s_q <= 1'b0;
			l1_q <= 1'b0;
			l0s_lat_q <= 16'h0000;
			l1_lat_q <= 16'h0000;
			oe_q <= 1'b1;
		end
		else if (clk_en)
		begin
			clkreq_q <= clkreq_d;
			es_q <= ctrl_q.extended_sync; // RULE_08
			ccc_q <= ctrl_q.common_clock_config;
			rcb_q <= ctrl_q.completion_boundary; // RULE_11
			l0s_q <= allow.l0s_entry_allow; // RULE_13
			l1_q <= allow.l1_entry_allow; // RULE_13
			l0s_lat_q <= l0s_lat_d;
			l1_lat_q <= l1_lat_d;
			// The request pin is always driven, so its enable is a constant high flop
			oe_q <= 1'b1;
		end
	end

	assign cfg_rdata = rdata_q;
	assign clkreq_out = clkreq_q;
	assign clkreq_oe = oe_q;
	assign extended_sync = es_q;
	assign common_clock_config = ccc_q;
	assign completion_boundary = rcb_q;
	assign l0s_entry_allow = l0s_q;
	assign l1_entry_allow = l1_q;
	assign l0s_exit_latency = l0s_lat_q;
	assign l1_exit_latency = l1_lat_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence seq_read_hit;
		cfg_rd && hit && clk_en;
	endsequence

	AST_FIXED_ZERO: assert property (@(posedge clk) disable iff (rst) // RULE_01
		seq_read_hit |=> (cfg_rdata[15:9] == 7'h00) && (cfg_rdata[5:4] == 2'h0))
		else $error("Fixed upper bits read nonzero");
	AST_BIT11: assert property (@(posedge clk) disable iff (rst) // RULE_02
		seq_read_hit |=> !cfg_rdata[11]) else $error("Bit 11 read nonzero");
	AST_BIT10: assert property (@(posedge clk) disable iff (rst) // RULE_03
		seq_read_hit |=> !cfg_rdata[10]) else $error("Bit 10 read nonzero");
	AST_BIT9: assert property (@(posedge clk) disable iff (rst) // RULE_04
		seq_read_hit |=> !cfg_rdata[9]) else $error("Bit 9 read nonzero");
	AST_BIT2: assert property (@(posedge clk) disable iff (rst) // RULE_12
		seq_read_hit |=> !cfg_rdata[2] && !cfg_rdata[5] && !cfg_rdata[4])
		else $error("Bit 2, 5 or 4 read nonzero"); // RULE_10
	AST_CLKREQ_LOW: assert property (@(posedge clk) disable iff (rst) // RULE_05
		(!ctrl_q.clock_pm_enable && clk_en) |=> !clkreq_out)
		else $error("Clock request released while disabled");
	AST_CLKREQ_REL: assert property (@(posedge clk) disable iff (rst) // RULE_06
		(ctrl_q.clock_pm_enable && link_idle_clock_ok && clk_en) |=> clkreq_out)
		else $error("Clock request not released");
	AST_STRAP: assert property (@(posedge clk) disable iff (rst) // RULE_07
		(!loaded_q && clk_en) |=> (ctrl_q.clock_pm_enable == $past(clock_pm_default_select))
		&& (ctrl_q.active_state_pm_control == $past(active_pm_default_select)))
		else $error("Defaults not loaded"); // RULE_14
	AST_WRITE: assert property (@(posedge clk) disable iff (rst) // RULE_15
		(loaded_q && cfg_wr && hit && clk_en && (cfg_byte_en == 2'h3)) |=>
		(image == ($past(cfg_wdata) & PLCR_WRITE_MASK)))
		else $error("Write did not land on writable bits only");
	AST_LATENCY: assert property (@(posedge clk) disable iff (rst) // RULE_09
		(clk_en && ctrl_q.common_clock_config) |=> (l1_exit_latency == L1_LAT_COMMON))
		else $error("Exit latency not common-clock value");
	AST_ASPM: assert property (@(posedge clk) disable iff (rst) // RULE_13
		(clk_en && ctrl_q.active_state_pm_control == PLCR_ASPM_OFF) |=>
		!l0s_entry_allow && !l1_entry_allow)
		else $error("Low-power entry allowed while disabled");
	AST_ES: assert property (@(posedge clk) disable iff (rst) // RULE_08
		clk_en |=> extended_sync == $past(ctrl_q.extended_sync))
		else $error("Extended sync output stale");
	AST_RCB: assert property (@(posedge clk) disable iff (rst) // RULE_11
		clk_en |=> completion_boundary == $past(ctrl_q.completion_boundary))
		else $error("Completion boundary output stale");

	// ----------------------------------------
	// Write, hold, read and output checks
	// ----------------------------------------
	sequence seq_write_hit;
		loaded_q && cfg_wr && hit && clk_en;
	endsequence

	sequence seq_write_other;
		loaded_q && cfg_wr && !hit && clk_en;
	endsequence

	sequence seq_no_write;
		!(cfg_wr && clk_en);
	endsequence

	AST_RL_LD: assert property (@(posedge clk) disable iff (rst) // RULE_10
		seq_read_hit |=> (cfg_rdata[5:4] == 2'h0))
		else $error("Retrain or link-off bit read nonzero");
	AST_OTHER_ADDR: assert property (@(posedge clk) disable iff (rst) // RULE_15
		seq_write_other |=> $stable(ctrl_q))
		else $error("Write to another offset changed the register");
	// Byte enables gate the fields of each byte; a partial write keeps the rest
	AST_HIGH_KEEP: assert property (@(posedge clk) disable iff (rst) // RULE_15
		(seq_write_hit ##0 !cfg_byte_en[1]) |=> $stable(ctrl_q.clock_pm_enable))
		else $error("Clock PM enable changed without its byte enable");
	AST_LOW_KEEP: assert property (@(posedge clk) disable iff (rst) // RULE_15
		(seq_write_hit ##0 !cfg_byte_en[0]) |=>
		$stable(ctrl_q.extended_sync) && $stable(ctrl_q.common_clock_config)
		&& $stable(ctrl_q.completion_boundary) && $stable(ctrl_q.active_state_pm_control))
		else $error("Low byte changed without its byte enable");
	// A read two cycles after a full write returns only the writable bits of that write
	AST_READBACK: assert property (@(posedge clk) disable iff (rst) // RULE_15
		(seq_write_hit ##0 (cfg_byte_en == 2'h3)) ##1 seq_no_write ##1 seq_read_hit |=>
		(cfg_rdata == ($past(cfg_wdata, 3) & PLCR_WRITE_MASK)))
		else $error("Read-back does not match the writable bits");
	AST_STRAP_HOLD: assert property (@(posedge clk) disable iff (rst) // RULE_07
		(loaded_q && clk_en && !(cfg_wr && hit)) |=> $stable(ctrl_q))
		else $error("Register changed without a write"); // RULE_14
	AST_FROZEN: assert property (@(posedge clk) disable iff (rst) // RULE_15
		!clk_en |=> $stable(ctrl_q) && $stable(cfg_rdata) && $stable(clkreq_out))
		else $error("State moved while the clock enable was low");
	AST_UNMAPPED: assert property (@(posedge clk) disable iff (rst) // RULE_15
		(cfg_rd && !hit && clk_en) |=> (cfg_rdata == 16'h0000))
		else $error("Unmapped read returned data");
	// Exit latencies follow the stored clock setting one enabled cycle later
	AST_LAT_SEP: assert property (@(posedge clk) disable iff (rst) // RULE_09
		(clk_en && !ctrl_q.common_clock_config) |=>
		(l0s_exit_latency == L0S_LAT_SEPARATE) && (l1_exit_latency == L1_LAT_SEPARATE))
		else $error("Exit latency not separate-clock value");
	AST_L0S_COMMON: assert property (@(posedge clk) disable iff (rst) // RULE_09
		(clk_en && ctrl_q.common_clock_config) |=> (l0s_exit_latency == L0S_LAT_COMMON))
		else $error("L0s exit latency not common-clock value");
	AST_CCC_OUT: assert property (@(posedge clk) disable iff (rst) // RULE_09
		clk_en |=> common_clock_config == $past(ctrl_q.common_clock_config))
		else $error("Common clock output stale");
	AST_ASPM_L0S: assert property (@(posedge clk) disable iff (rst) // RULE_13
		(clk_en && ctrl_q.active_state_pm_control == PLCR_ASPM_L0S) |=>
		l0s_entry_allow && !l1_entry_allow)
		else $error("L0s-only setting decoded wrongly");
	AST_ASPM_L1: assert property (@(posedge clk) disable iff (rst) // RULE_13
		(clk_en && ctrl_q.active_state_pm_control == PLCR_ASPM_L1) |=>
		!l0s_entry_allow && l1_entry_allow)
		else $error("L1-only setting decoded wrongly");
	AST_ASPM_BOTH: assert property (@(posedge clk) disable iff (rst) // RULE_13
		(clk_en && ctrl_q.active_state_pm_control == PLCR_ASPM_BOTH) |=>
		l0s_entry_allow && l1_entry_allow)
		else $error("Both-states setting decoded wrongly");
	AST_OE: assert property (@(posedge clk) disable iff (rst) clkreq_oe) // RULE_05
		else $error("Clock request pin not driven");
endmodule
`default_nettype wire

// ### plcr_link_partner.sv
`timescale 1ns/100ps
`default_nettype none
module plcr_link_partner
#(
	parameter int DELAY = 2
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic go_idle,
	output logic link_idle_clock_ok
);
	// Idle is granted only after the link has been quiet for DELAY cycles
	logic [3:0] cnt_q;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cnt_q <= 4'h0;
		else if (!go_idle)
			cnt_q <= 4'h0;
		else if (cnt_q != DELAY[3:0])
			cnt_q <= cnt_q + 4'h1;
	end
	assign link_idle_clock_ok = go_idle && (cnt_q == DELAY[3:0]);
endmodule
`default_nettype wire

// ### plcr_pkg.sv
`default_nettype none
package plcr_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] PLCR_LINK_CTRL_OFFSET = 8'h80;
	localparam int PLCR_REG_WIDTH = 16;
	// Field positions
	localparam int PLCR_CLOCK_PM_BIT = 8;
	localparam int PLCR_EXT_SYNC_BIT = 7;
	localparam int PLCR_COMMON_CLK_BIT = 6;
	localparam int PLCR_COMPL_BND_BIT = 3;
	localparam int PLCR_ASPM_LSB = 0;
	// Writable bits 8,7,6,3,1,0
	localparam logic [15:0] PLCR_WRITE_MASK = 16'h01cb;
	// Reset values of fields not taken from the general control register
	localparam logic PLCR_EXT_SYNC_RESET = 1'b0;
	localparam logic PLCR_COMMON_CLK_RESET = 1'b0;
	localparam logic PLCR_COMPL_BND_RESET = 1'b0;
	// Field values of the active state PM control
	localparam logic [1:0] PLCR_ASPM_OFF = 2'h0;
	localparam logic [1:0] PLCR_ASPM_L0S = 2'h1;
	localparam logic [1:0] PLCR_ASPM_L1 = 2'h2;
	localparam logic [1:0] PLCR_ASPM_BOTH = 2'h3;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic clock_pm_enable;
		logic extended_sync;
		logic common_clock_config;
		logic completion_boundary;
		logic [1:0] active_state_pm_control;
	} plcr_ctrl_type;

	typedef struct packed {
		logic l0s_entry_allow;
		logic l1_entry_allow;
	} plcr_aspm_type;
endpackage
`default_nettype wire

// ### testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
	import plcr_pkg::*;
;
	logic clk = 0, rst = 1, clk_en = 1, cpm_def = 0, cfg_wr = 0, cfg_rd = 0, go_idle = 0;
	logic [1:0] aspm_def = 0, be = 0;
	logic [7:0] addr = 0;
	logic [15:0] wdata = 0, img, rdata, l0s_lat, l1_lat, d;
	logic idle_ok, clkreq, oe, es, cc, cb, l0s, l1;
	logic [15:0] exp_q[$];
	int bad_count = 0, tests_run = 0;
	bit pend = 0;
	always #20 clk = ~clk;
	plcr_link_control #(.L0S_LAT_COMMON(16'h0011), .L0S_LAT_SEPARATE(16'h0022),
		.L1_LAT_COMMON(16'h0033), .L1_LAT_SEPARATE(16'h0044)) plcr_link_control_i (
		.clk(clk), .rst(rst), .clk_en(clk_en), .clock_pm_default_select(cpm_def),
		.active_pm_default_select(aspm_def), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
		.cfg_addr(addr), .cfg_byte_en(be), .cfg_wdata(wdata), .cfg_rdata(rdata),
		.link_idle_clock_ok(idle_ok), .clkreq_out(clkreq), .clkreq_oe(oe),
		.extended_sync(es), .common_clock_config(cc), .completion_boundary(cb),
		.l0s_entry_allow(l0s), .l1_entry_allow(l1), .l0s_exit_latency(l0s_lat),
		.l1_exit_latency(l1_lat));
	plcr_link_partner plcr_link_partner_i (.clk(clk), .rst(rst), .go_idle(go_idle),
		.link_idle_clock_ok(idle_ok));
	// ----------------------------------------
	// Checking
	// ----------------------------------------
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic close_out();
		if (bad_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Read data is registered, so it is compared one edge after the read is taken
	always @(posedge clk)
	begin
		if (pend && exp_q.size() > 0)
			check("cfg_rdata", rdata, exp_q.pop_front());
		pend = cfg_rd && clk_en;
	end
	initial
	begin
		#(40 * 5000);
		bad_count++;
		close_out();
	end
	// ----------------------------------------
	// Drivers
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [1:0] b, input logic [15:0] v);
		@(negedge clk);
		addr = a;
		be = b;
		wdata = v;
		cfg_wr = 1;
		@(negedge clk);
		cfg_wr = 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(negedge clk);
		exp_q.push_back(exp);
		addr = a;
		cfg_rd = 1;
		@(negedge clk);
		cfg_rd = 0;
	endtask
	task automatic link_chk();
		repeat (4) @(negedge clk);
		check("ext_sync", es, img[7]);
		check("common_clk", cc, img[6]);
		check("boundary", cb, img[3]);
		check("l0s_allow", l0s, img[0]);
		check("l1_allow", l1, img[1]);
		check("l0s_lat", l0s_lat, img[6] ? 16'h0011 : 16'h0022);
		check("l1_lat", l1_lat, img[6] ? 16'h0033 : 16'h0044);
		check("clkreq", clkreq, img[8] & idle_ok);
		check("clkreq_oe", oe, 1'b1);
	endtask
	initial
	begin
		void'($urandom(32'h61b17101));
		for (int i = 0; i < 4; i++)
		begin
			// Each pass is a fresh reset with new defaults from the general control
			cpm_def = 1'($urandom);
			aspm_def = i[1:0];
			go_idle = 1'($urandom);
			rst = 1;
			repeat (8) @(negedge clk);
			rst = 0;
			repeat (3) @(negedge clk);
			img = {7'h00, cpm_def, 6'h00, aspm_def};
			rd(8'h80, img);
			link_chk();
		end
		go_idle = 1;
		wr(8'h80, 2'h3, 16'hffff);
		img = 16'h01cb;
		rd(8'h80, img);
		link_chk();
		wr(8'h80, 2'h3, 16'h0000);
		img = 16'h0000;
		rd(8'h80, img);
		link_chk();
		for (int i = 0; i < 16; i++)
		begin
			d = 16'($urandom);
			be = 2'($urandom);
			go_idle = 1'($urandom);
			wr(8'h80, be, d);
			img = (img & ~({{8{be[1]}}, {8{be[0]}}} & 16'h01cb))
				| (d & {{8{be[1]}}, {8{be[0]}}} & 16'h01cb);
			rd(8'h80, img);
			link_chk();
		end
		wr(8'h84, 2'h3, ~img);
		rd(8'h84, 16'h0000);
		rd(8'h80, img);
		@(negedge clk);
		clk_en = 0;
		wr(8'h80, 2'h3, ~img);
		clk_en = 1;
		rd(8'h80, img);
		repeat (3) @(negedge clk);
		close_out();
	end
endmodule
`default_nettype wire
